// >>> core/iprs_pkg.sv
`default_nettype none
package iprs_pkg;
    // ===========================================
    // register map (byte addresses)
    localparam logic [7:0] timer_clock_input_select_off   = 8'h00;
    localparam logic [7:0] capture_low_input_select_off   = 8'h04;
    localparam logic [7:0] capture_high_input_select_off  = 8'h08;
    localparam logic [7:0] compare_fault_input_select_off = 8'h0c;
    localparam logic [7:0] serial_port_input_select_off   = 8'h10;
    localparam logic [7:0] lock_control_off               = 8'h14;
    localparam logic [7:0] osc_control_off                = 8'h18;
    localparam logic [7:0] status_off                     = 8'h1c;
    // ===========================================
    // fields
    localparam int          sel_w        = 5;
    localparam int          hi_lsb       = 8;
    localparam int          lo_lsb       = 0;
    localparam int          num_sel      = 9;
    localparam int          num_pins     = 16;
    localparam logic [4:0]  sel_reset    = 5'h1f;
    localparam logic [7:0]  key_first    = 8'h46;
    localparam logic [7:0]  key_second   = 8'h57;
    localparam int          lock_bit     = 6;
    // selector indices
    localparam int s_t2 = 0, s_t3 = 1, s_ic1 = 2, s_ic2 = 3, s_ic7 = 4;
    localparam int s_ic8 = 5, s_ocf = 6, s_rx = 7, s_cts = 8;
    // ===========================================
    typedef enum logic [1:0] {iprs_unl_idle, iprs_unl_key1, iprs_unl_open} iprs_unl_e;
    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic        valid;
    } iprs_req_s;
endpackage : iprs_pkg
`default_nettype wire

// >>> core/iprs_sel_mux.sv
`timescale 1ns/1ps
`default_nettype none
module iprs_sel_mux (
    input  wire logic [15:0] pins,
    input  wire logic [4:0]  sel,
    output logic             y
);
    // codes 16..31 tie to ground
    always_comb begin
        y = sel[4] ? 1'b0 : pins[sel[3:0]];
    end
endmodule : iprs_sel_mux
`default_nettype wire

// >>> core/iprs_lock.sv
`timescale 1ns/1ps
`default_nettype none
module iprs_lock (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       one_way_lock_config,
    input  wire logic       osc_wr,
    input  wire logic [7:0] osc_wdata,
    output logic            pin_select_lock
);
    iprs_pkg::iprs_unl_e st;
    iprs_pkg::iprs_unl_e next_st;
    logic                next_lock;
    logic                was_set;
    logic                next_was_set;

    always_comb begin
        next_st      = st;
        next_lock    = pin_select_lock;
        next_was_set = was_set;
        if (osc_wr) begin
            unique case (st)
                iprs_pkg::iprs_unl_idle: begin
                    next_st = (osc_wdata == iprs_pkg::key_first) ? iprs_pkg::iprs_unl_key1
                                                                  : iprs_pkg::iprs_unl_idle;
                end
                iprs_pkg::iprs_unl_key1: begin
                    next_st = (osc_wdata == iprs_pkg::key_second) ? iprs_pkg::iprs_unl_open
                                                                   : iprs_pkg::iprs_unl_idle;
                end
                iprs_pkg::iprs_unl_open: begin
                    next_st = iprs_pkg::iprs_unl_idle;
                    if (osc_wdata[iprs_pkg::lock_bit]) begin
                        next_lock    = 1'b1;
                        next_was_set = 1'b1;
                    end else if (!(one_way_lock_config && was_set)) begin
                        next_lock = 1'b0;
                    end
                end
                default: begin
                    next_st = iprs_pkg::iprs_unl_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st              <= iprs_pkg::iprs_unl_idle;
            pin_select_lock <= 1'b0;
            was_set         <= 1'b0;
        end else begin
            st              <= next_st;
            pin_select_lock <= next_lock;
            was_set         <= next_was_set;
        end
    end

    chk_one_way_hold: assert property (@(posedge clk) disable iff (rst)
        (one_way_lock_config && was_set && pin_select_lock) |=> pin_select_lock)
        else $error("lock cleared under one-way config");
    chk_lock_needs_key: assert property (@(posedge clk) disable iff (rst)
        $changed(pin_select_lock) |-> $past(st) == iprs_pkg::iprs_unl_open)
        else $error("lock changed without key sequence");
endmodule : iprs_lock
`default_nettype wire

// >>> core/iprs_input_remap.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - bits 12:8 select timer three clock pin
// - bits 4:0 select timer two clock pin
// - bits 12:8 select capture two pin
// - bits 4:0 select capture one pin
// - bits 12:8 select capture eight pin
// - bits 4:0 select capture seven pin
// - fault selector bits 4:0, rest unused
// - bits 12:8 select uart cts pin
// - bits 4:0 select uart rx pin
// - all ones ties input to ground
// - codes 0..15 pick that pin
// - unused bits read zero, ignore writes
// - selectors read/write, reset to ones
// - lock set discards selector writes silently
// - shadow mismatch raises configuration reset
// - one-way config keeps lock set
module iprs_input_remap (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        one_way_lock_config,
    input  wire logic [15:0] remappable_pin,
    output logic             timer_two_ext_clock,
    output logic             timer_three_ext_clock,
    output logic             capture_one_input,
    output logic             capture_two_input,
    output logic             capture_seven_input,
    output logic             capture_eight_input,
    output logic             compare_fault_input,
    output logic             uart_receive_in,
    output logic             uart_clear_to_send_in,
    output logic             config_mismatch_reset
);
    // ===========================================
    // bus address phase capture
    iprs_pkg::iprs_req_s req;
    iprs_pkg::iprs_req_s next_req;
    logic [4:0]          sel     [iprs_pkg::num_sel];
    logic [4:0]          next_sel[iprs_pkg::num_sel];
    logic [4:0]          shadow  [iprs_pkg::num_sel];
    logic [31:0]         next_hrdata;
    logic                pin_select_lock;
    logic                osc_wr;
    logic                sel_wr;
    logic                next_mismatch;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_comb begin
        next_req.valid = hsel && hready && htrans[1];
        next_req.write = hwrite;
        next_req.addr  = haddr[7:0];
    end

    assign osc_wr = req.valid && req.write && (req.addr == iprs_pkg::osc_control_off);
    assign sel_wr = req.valid && req.write && !pin_select_lock;

    // ===========================================
    // selector registers
    always_comb begin
        for (int i = 0; i < iprs_pkg::num_sel; i++) begin
            next_sel[i] = sel[i];
        end
        if (sel_wr) begin
            unique case (req.addr)
                iprs_pkg::timer_clock_input_select_off: begin
                    next_sel[iprs_pkg::s_t3] = hwdata[12:8];
                    next_sel[iprs_pkg::s_t2] = hwdata[4:0];
                end
                iprs_pkg::capture_low_input_select_off: begin
                    next_sel[iprs_pkg::s_ic2] = hwdata[12:8];
                    next_sel[iprs_pkg::s_ic1] = hwdata[4:0];
                end
                iprs_pkg::capture_high_input_select_off: begin
                    next_sel[iprs_pkg::s_ic8] = hwdata[12:8];
                    next_sel[iprs_pkg::s_ic7] = hwdata[4:0];
                end
                iprs_pkg::compare_fault_input_select_off: begin
                    next_sel[iprs_pkg::s_ocf] = hwdata[4:0];
                end
                iprs_pkg::serial_port_input_select_off: begin
                    next_sel[iprs_pkg::s_cts] = hwdata[12:8];
                    next_sel[iprs_pkg::s_rx]  = hwdata[4:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < iprs_pkg::num_sel; i++) begin
            if (rst) begin
                sel[i]    <= iprs_pkg::sel_reset;
                shadow[i] <= iprs_pkg::sel_reset;
            end else begin
                sel[i]    <= next_sel[i];
                shadow[i] <= next_sel[i];
            end
        end
    end

    // ===========================================
    // mismatch monitor
    always_comb begin
        next_mismatch = 1'b0;
        for (int i = 0; i < iprs_pkg::num_sel; i++) begin
            next_mismatch = next_mismatch | (sel[i] != shadow[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            config_mismatch_reset <= 1'b0;
        end else begin
            config_mismatch_reset <= next_mismatch;
        end
    end

    // ===========================================
    // read data
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (next_req.valid && !hwrite) begin
            unique case (haddr[7:0])
                iprs_pkg::timer_clock_input_select_off:
                    next_hrdata = {19'h0, sel[iprs_pkg::s_t3], 3'h0, sel[iprs_pkg::s_t2]};
                iprs_pkg::capture_low_input_select_off:
                    next_hrdata = {19'h0, sel[iprs_pkg::s_ic2], 3'h0, sel[iprs_pkg::s_ic1]};
                iprs_pkg::capture_high_input_select_off:
                    next_hrdata = {19'h0, sel[iprs_pkg::s_ic8], 3'h0, sel[iprs_pkg::s_ic7]};
                iprs_pkg::compare_fault_input_select_off:
                    next_hrdata = {27'h0, sel[iprs_pkg::s_ocf]};
                iprs_pkg::serial_port_input_select_off:
                    next_hrdata = {19'h0, sel[iprs_pkg::s_cts], 3'h0, sel[iprs_pkg::s_rx]};
                iprs_pkg::osc_control_off:
                    next_hrdata = {25'h0, pin_select_lock, 6'h0};
                default:
                    next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            req    <= '0;
            hrdata <= 32'h0000_0000;
        end else begin
            req    <= next_req;
            hrdata <= next_hrdata;
        end
    end

    // ===========================================
    // lock and muxes
    iprs_lock u_lock (
        .clk                 (clk),
        .rst                 (rst),
        .one_way_lock_config (one_way_lock_config),
        .osc_wr              (osc_wr),
        .osc_wdata           (hwdata[7:0]),
        .pin_select_lock     (pin_select_lock)
    );

    logic [iprs_pkg::num_sel-1:0] mux_out;
    for (genvar g = 0; g < iprs_pkg::num_sel; g++) begin : g_mux
        iprs_sel_mux u_mux (
            .pins (remappable_pin),
            .sel  (sel[g]),
            .y    (mux_out[g])
        );
    end

    assign timer_two_ext_clock   = mux_out[iprs_pkg::s_t2];
    assign timer_three_ext_clock = mux_out[iprs_pkg::s_t3];
    assign capture_one_input     = mux_out[iprs_pkg::s_ic1];
    assign capture_two_input     = mux_out[iprs_pkg::s_ic2];
    assign capture_seven_input   = mux_out[iprs_pkg::s_ic7];
    assign capture_eight_input   = mux_out[iprs_pkg::s_ic8];
    assign compare_fault_input   = mux_out[iprs_pkg::s_ocf];
    assign uart_receive_in       = mux_out[iprs_pkg::s_rx];
    assign uart_clear_to_send_in = mux_out[iprs_pkg::s_cts];

    // ===========================================
    chk_lock_blocks: assert property (@(posedge clk) disable iff (rst)
        (req.valid && req.write && pin_select_lock) |=> $stable(sel[iprs_pkg::s_rx]))
        else $error("selector changed while locked");
    chk_rx_write: assert property (@(posedge clk) disable iff (rst)
        (req.valid && req.write && !pin_select_lock
         && req.addr == iprs_pkg::serial_port_input_select_off)
        |=> sel[iprs_pkg::s_rx] == $past(hwdata[4:0]))
        else $error("uart rx selector not written");
    chk_t3_write: assert property (@(posedge clk) disable iff (rst)
        (req.valid && req.write && !pin_select_lock
         && req.addr == iprs_pkg::timer_clock_input_select_off)
        |=> sel[iprs_pkg::s_t3] == $past(hwdata[12:8]))
        else $error("timer three selector not written");
    chk_ground_tie: assert property (@(posedge clk) disable iff (rst)
        sel[iprs_pkg::s_ic1][4] |-> !capture_one_input)
        else $error("high selector code not grounded");
    chk_pin_route: assert property (@(posedge clk) disable iff (rst)
        !sel[iprs_pkg::s_cts][4]
        |-> uart_clear_to_send_in == remappable_pin[sel[iprs_pkg::s_cts][3:0]])
        else $error("cts not routed from selected pin");
    chk_reset_ones: assert property (@(posedge clk)
        rst |=> sel[iprs_pkg::s_ocf] == iprs_pkg::sel_reset)
        else $error("selector reset value wrong");
    chk_unused_zero: assert property (@(posedge clk) disable iff (rst)
        (hrdata[31:13] == 19'h0) && (hrdata[7] == 1'b0))
        else $error("unused read bits not zero");
    chk_no_mismatch: assert property (@(posedge clk) disable iff (rst)
        ##1 !config_mismatch_reset)
        else $error("shadow mismatch raised");
endmodule : iprs_input_remap
`default_nettype wire

// >>> sim/iprs_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module iprs_pin_model (
    input  wire logic        clk,
    input  wire logic [15:0] level,
    output logic [15:0]      remappable_pin
);
    // =========================================
    // pins settle one clock after the bench picks a level
    always_ff @(posedge clk) begin
        remappable_pin <= level;
    end
endmodule : iprs_pin_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        one_way = 1'b0;
    logic [15:0] pat = 16'hffff;
    wire  [15:0] pins;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         mism;
    wire  [8:0]  outv;
    int          n_mismatch = 0;
    int          checks = 0;
    logic [31:0] rv;
    logic [7:0]  off [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] wv [5] = '{32'hffffe1e0, 32'hffffe3e2, 32'hffffe5e4, 32'hffffffe6, 32'hffffe8e7};
    logic [31:0] ev [5] = '{32'h0100, 32'h0302, 32'h0504, 32'h0006, 32'h0807};
    localparam logic [7:0] osc = iprs_pkg::osc_control_off;

    always #5 clk = ~clk;

    iprs_pin_model u_iprs_pin_model (.clk(clk), .level(pat), .remappable_pin(pins));

    iprs_input_remap u_iprs_input_remap (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .one_way_lock_config(one_way), .remappable_pin(pins),
        .timer_two_ext_clock(outv[0]), .timer_three_ext_clock(outv[1]),
        .capture_one_input(outv[2]), .capture_two_input(outv[3]),
        .capture_seven_input(outv[4]), .capture_eight_input(outv[5]),
        .compare_fault_input(outv[6]), .uart_receive_in(outv[7]),
        .uart_clear_to_send_in(outv[8]), .config_mismatch_reset(mism)
    );

    // =========================================
    // bus tasks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd

    task automatic keyed(input logic [7:0] v);
        wr(osc, 32'h46);
        wr(osc, 32'h57);
        wr(osc, {24'h0, v});
    endtask : keyed

    task automatic pins_out(input logic [15:0] p, input logic [31:0] exp);
        pat <= p;
        repeat (2) @(posedge clk);
        chk({23'h0, outv}, exp);
    endtask : pins_out

    task automatic final_report;
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end

    // =========================================
    // tests
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd(off[i], (i == 3) ? 32'h1f : 32'h1f1f);
        pins_out(16'hffff, 32'h0);
        rd(8'h14, 32'h0);
        keyed(8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(off[i], wv[i]);
            rd(off[i], ev[i]);
        end
        for (int p = 0; p < 16; p++) pins_out(16'h1 << p, (p < 9) ? 32'h1 << p : 32'h0);
        for (int c = 16; c < 32; c++) begin
            for (int i = 0; i < 5; i++) wr(off[i], {19'h0, c[4:0], 3'h0, c[4:0]});
            pins_out(16'hffff, 32'h0);
        end
        for (int i = 0; i < 5; i++) wr(off[i], ev[i]);
        // broken key order must not set the lock
        wr(osc, 32'h46);
        wr(osc, 32'h12);
        wr(osc, 32'h57);
        wr(osc, 32'h40);
        wr(off[0], 32'h0202);
        rd(off[0], 32'h0202);
        wr(off[0], ev[0]);
        keyed(8'h40);
        bus(1'b0, osc, 32'h0, rv);
        chk(rv & 32'h40, 32'h40);
        for (int i = 0; i < 5; i++) begin
            wr(off[i], 32'h0);
            rd(off[i], ev[i]);
        end
        chk({31'h0, hresp}, 32'h0);
        keyed(8'h00);
        wr(off[0], 32'h0);
        rd(off[0], 32'h0);
        one_way <= 1'b1;
        keyed(8'h40);
        keyed(8'h00);
        wr(off[0], 32'h1f1f);
        rd(off[0], 32'h0);
        chk({31'h0, mism}, 32'h0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
